//--- src/mwr_params.svh
// constants for the modulo address wrap block
`ifndef MWR_PARAMS_SVH
`define MWR_PARAMS_SVH
`define MWR_OFF_CONTROL  12'h000
`define MWR_OFF_XSTART   12'h004
`define MWR_OFF_XEND     12'h008
`define MWR_OFF_YSTART   12'h00c
`define MWR_OFF_YEND     12'h010
`define MWR_OFF_STATUS   12'h014
`define MWR_XSEL_LSB     0
`define MWR_YSEL_LSB     4
`define MWR_YEN_BIT      14
`define MWR_XEN_BIT      15
`define MWR_SEL_OFF      4'hf
`define MWR_CTRL_RST     16'h0000
`define MWR_CTRL_INIT    16'h00ff
`define MWR_ADDR_RST     16'h0000
`define MWR_RESP_OKAY    2'b00
`define MWR_RESP_SLVERR  2'b10
`endif

//--- src/mwr_pkg.sv
// types for the modulo address wrap block
package mwr_pkg;
  typedef enum logic [1:0] {
    MWR_DIR_NONE = 2'b00,
    MWR_DIR_INC  = 2'b01,
    MWR_DIR_DEC  = 2'b10
  } mwr_dir_t;
  typedef enum logic [0:0] {
    MWR_B_IDLE = 1'b0,
    MWR_B_RESP = 1'b1
  } mwr_bstate_t;
endpackage

//--- src/mwr_top.sv
// modulo address wrap block: buffer registers, axi4-lite slave, x and y wrap logic
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "mwr_params.svh"
module mwr_top #(
  parameter int AW = 12  // axi byte address width
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // x space address generators (read and write share one buffer, also used for program space)
  input  wire logic [3:0]    x_rd_ptr_sel,
  input  wire logic [15:0]   x_rd_addr,
  input  wire logic [1:0]    x_rd_dir,
  output logic [15:0]        x_rd_addr_out,
  input  wire logic [3:0]    x_wr_ptr_sel,
  input  wire logic [15:0]   x_wr_addr,
  input  wire logic [1:0]    x_wr_dir,
  output logic [15:0]        x_wr_addr_out,
  // y space address generator
  input  wire logic [3:0]    y_ptr_sel,
  input  wire logic [15:0]   y_addr,
  input  wire logic [1:0]    y_dir,
  output logic [15:0]        y_addr_out,
  output logic               x_wrap_hit,
  output logic               y_wrap_hit
);

  logic [15:0] modulo_control_r;  // select fields and enables
  logic [15:0] x_buffer_start_r;  // x buffer bounds
  logic [15:0] x_buffer_end_r;
  logic [15:0] y_buffer_start_r;  // y buffer bounds, start even, end odd once written
  logic [15:0] y_buffer_end_r;
  logic        x_wrap_r;          // sticky-free last-cycle wrap flags
  logic        y_wrap_r;

  // wrap one effective address against a buffer; the end is checked on increment and the start on decrement,
  // so buffers of any length work in either direction
  function automatic logic [16:0] wrap_ea(input logic [15:0] ea, input logic [1:0] dir,
                                          input logic [15:0] lo, input logic [15:0] hi);
    logic [16:0] res;
    res = {1'b0, ea};
    if (dir == mwr_pkg::MWR_DIR_INC && ea > hi) begin
      res = {1'b1, lo};
    end else if (dir == mwr_pkg::MWR_DIR_DEC && ea < lo) begin
      res = {1'b1, hi};
    end
    return res;
  endfunction

  // pointer selects and enables
  wire [3:0] x_sel = modulo_control_r[`MWR_XSEL_LSB +: 4];
  wire [3:0] y_sel = modulo_control_r[`MWR_YSEL_LSB +: 4];
  wire x_on = (x_sel != `MWR_SEL_OFF) && modulo_control_r[`MWR_XEN_BIT];
  wire y_on = (y_sel != `MWR_SEL_OFF) && modulo_control_r[`MWR_YEN_BIT];
  // buffer length in bytes minus one, from the bounds only
  wire [15:0] x_len = x_buffer_end_r - x_buffer_start_r;
  wire [15:0] y_len = y_buffer_end_r - y_buffer_start_r;

  // x read and write generators use the same buffer, program space included
  wire        x_rd_use = x_on && (x_rd_ptr_sel == x_sel);
  wire        x_wr_use = x_on && (x_wr_ptr_sel == x_sel);
  wire [16:0] x_rd_w = wrap_ea(x_rd_addr, x_rd_dir, x_buffer_start_r, x_buffer_end_r);
  wire [16:0] x_wr_w = wrap_ea(x_wr_addr, x_wr_dir, x_buffer_start_r, x_buffer_end_r);
  // y space is word only, so the low bit is cleared before and after
  wire        y_use = y_on && (y_ptr_sel == y_sel);
  wire [15:0] y_ea = {y_addr[15:1], 1'b0};
  wire [16:0] y_w = wrap_ea(y_ea, y_dir, y_buffer_start_r, y_buffer_end_r);

  assign x_rd_addr_out = x_rd_use ? x_rd_w[15:0] : x_rd_addr;
  assign x_wr_addr_out = x_wr_use ? x_wr_w[15:0] : x_wr_addr;
  assign y_addr_out    = y_use ? {y_w[15:1], 1'b0} : y_addr;
  wire x_hit_now = (x_rd_use && x_rd_w[16]) || (x_wr_use && x_wr_w[16]);
  wire y_hit_now = y_use && y_w[16];
  assign x_wrap_hit = x_wrap_r;
  assign y_wrap_hit = y_wrap_r;

  // ---- axi4-lite write path: address and data taken in either order
  logic              aw_held_r;
  logic              w_held_r;
  logic [AW-1:0]     aw_addr_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  mwr_pkg::mwr_bstate_t bst_r;
  logic [1:0]        bresp_r;
  assign s_axi_awready = !aw_held_r && (bst_r == mwr_pkg::MWR_B_IDLE);
  assign s_axi_wready  = !w_held_r && (bst_r == mwr_pkg::MWR_B_IDLE);
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs  = s_axi_wvalid && s_axi_wready;
  wire            aw_ok  = aw_held_r || aw_hs;
  wire            w_ok   = w_held_r || w_hs;
  wire            do_wr  = aw_ok && w_ok && (bst_r == mwr_pkg::MWR_B_IDLE);
  wire [AW-1:0]   wa     = aw_held_r ? aw_addr_r : s_axi_awaddr;
  wire [31:0]     wd     = w_held_r ? w_data_r : s_axi_wdata;
  wire [3:0]      ws     = w_held_r ? w_strb_r : s_axi_wstrb;
  wire [15:0]     wmask  = {{8{ws[1]}}, {8{ws[0]}}};
  wire            wa_ok  = (wa[11:0] <= `MWR_OFF_YEND) && (wa[1:0] == 2'b00);
  assign s_axi_bvalid = (bst_r == mwr_pkg::MWR_B_RESP);
  assign s_axi_bresp  = bresp_r;

  // merge a strobed write into a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [15:0] m);
    return (old & ~m) | (nw & m);
  endfunction

  // write channel holding and response state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bst_r     <= mwr_pkg::MWR_B_IDLE;
      bresp_r   <= `MWR_RESP_OKAY;
    end else begin
      if (do_wr) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bst_r     <= mwr_pkg::MWR_B_RESP;
        bresp_r   <= wa_ok ? `MWR_RESP_OKAY : `MWR_RESP_SLVERR;
      end else begin
        if (aw_hs) begin
          aw_held_r <= 1'b1;
          aw_addr_r <= s_axi_awaddr;
        end
        if (w_hs) begin
          w_held_r <= 1'b1;
          w_data_r <= s_axi_wdata;
          w_strb_r <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          bst_r <= mwr_pkg::MWR_B_IDLE;
        end
      end
    end
  end

  // register file; y start keeps bit 0 clear, y end gets bit 0 set on every write (reset loads 0)
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      modulo_control_r <= `MWR_CTRL_INIT;
      x_buffer_start_r <= `MWR_ADDR_RST;
      x_buffer_end_r   <= `MWR_ADDR_RST;
      y_buffer_start_r <= `MWR_ADDR_RST;
      y_buffer_end_r   <= `MWR_ADDR_RST;
    end else if (do_wr && wa_ok) begin
      case (wa[11:0])
        `MWR_OFF_CONTROL: modulo_control_r <= merge(modulo_control_r, wd[15:0], wmask);
        `MWR_OFF_XSTART:  x_buffer_start_r <= merge(x_buffer_start_r, wd[15:0], wmask);
        `MWR_OFF_XEND:    x_buffer_end_r   <= merge(x_buffer_end_r, wd[15:0], wmask);
        `MWR_OFF_YSTART:  y_buffer_start_r <= merge(y_buffer_start_r, wd[15:0], wmask) & 16'hfffe;
        `MWR_OFF_YEND:    y_buffer_end_r   <= merge(y_buffer_end_r, wd[15:0], wmask) | 16'h0001;
        default:          modulo_control_r <= modulo_control_r;
      endcase
    end
  end

  // wrap indication, one cycle after the access
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      x_wrap_r <= 1'b0;
      y_wrap_r <= 1'b0;
    end else begin
      x_wrap_r <= x_hit_now;
      y_wrap_r <= y_hit_now;
    end
  end

  // ---- axi4-lite read path: one read outstanding, answer one cycle after address
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire ra_ok = (s_axi_araddr[11:0] <= `MWR_OFF_STATUS) && (s_axi_araddr[1:0] == 2'b00);
  logic [15:0] rsel;
  // read mux; status shows live enables and wrap flags, the x length in bits 31:16 and y length bits 11:0 in bits 11:0
  always_comb begin
    rsel = 16'h0000;
    case (s_axi_araddr[11:0])
      `MWR_OFF_CONTROL: rsel = modulo_control_r;
      `MWR_OFF_XSTART:  rsel = x_buffer_start_r;
      `MWR_OFF_XEND:    rsel = x_buffer_end_r;
      `MWR_OFF_YSTART:  rsel = y_buffer_start_r;
      `MWR_OFF_YEND:    rsel = y_buffer_end_r;
      `MWR_OFF_STATUS:  rsel = {y_on, x_on, y_wrap_r, x_wrap_r, 12'h000};
      default:          rsel = 16'h0000;
    endcase
  end
  wire [31:0] rword = (s_axi_araddr[11:0] == `MWR_OFF_STATUS) ? {x_len, rsel} : {16'h0000, rsel};
  wire [15:0] y_len_unused_guard = y_len;

  // read response register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `MWR_RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_r <= 1'b1;
      rdata_r  <= ra_ok ? ((s_axi_araddr[11:0] == `MWR_OFF_STATUS) ?
                  {x_len, rsel[15:12], 12'h000} | {16'h0000, 4'h0, y_len_unused_guard[11:0]} : rword) : 32'h0000_0000;
      rresp_r  <= ra_ok ? `MWR_RESP_OKAY : `MWR_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule // mwr_top

//--- verification/mwr_checker.sv
// port assertions for the modulo address wrap block
`timescale 1ns/1ps
module mwr_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        s_axi_arready,
  input wire logic        x_wrap_hit,
  input wire logic [3:0]  x_rd_ptr_sel,
  input wire logic [3:0]  y_ptr_sel,
  input wire logic [1:0]  x_rd_dir,
  input wire logic [1:0]  x_wr_dir,
  input wire logic [1:0]  y_dir,
  input wire logic [15:0] x_rd_addr,
  input wire logic [15:0] x_rd_addr_out,
  input wire logic [15:0] y_addr,
  input wire logic [15:0] y_addr_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a response waiting for the master
  sequence b_wait; s_axi_bvalid && !s_axi_bready; endsequence
  sequence r_wait; s_axi_rvalid && !s_axi_rready; endsequence
  b_hold_a: assert property (b_wait |=> s_axi_bvalid) else $error("write response dropped early");
  r_hold_a: assert property (r_wait |=> s_axi_rvalid) else $error("read response dropped early");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  // a y address that the block alters is always a word address; a passed-through one may be odd
  y_even_a: assert property (y_addr_out != y_addr |-> !y_addr_out[0]) else $error("odd y address");
  x_idle_a: assert property (x_rd_dir == 2'b00 |-> x_rd_addr_out == x_rd_addr) else $error("x moved");
  y_idle_a: assert property (y_dir == 2'b00 |-> y_addr_out[15:1] == y_addr[15:1]) else $error("y moved");
  x_off_a: assert property (x_rd_ptr_sel == 4'hf |-> x_rd_addr_out == x_rd_addr) else $error("x wrap off");
  y_off_a: assert property (y_ptr_sel == 4'hf |-> y_addr_out == y_addr) else $error("y off");
  // a wrap flag needs a moving access one cycle before
  x_hit_cause_a: assert property (x_wrap_hit |-> $past(x_rd_dir) != 2'b00 || $past(x_wr_dir) != 2'b00)
    else $error("x wrap flag without access");
endmodule // mwr_checker
bind mwr_top mwr_checker mwr_checker_inst (.*);

//--- verification/mwr_core_model.sv
// core pointer model feeding one address generator of the wrap block
`timescale 1ns/1ps
module mwr_core_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        load,
  input  wire logic [15:0] load_val,
  input  wire logic [15:0] addr_back,
  input  wire logic [1:0]  dir_in,
  output logic [15:0]      cand
);
  logic [15:0] ptr_r; // pointer register inside the core
  // word step up or down; the wrap block has the final say
  assign cand = (dir_in == 2'b01) ? ptr_r + 16'h0002 : (dir_in == 2'b10) ? ptr_r - 16'h0002 : ptr_r;
  // the core keeps whatever address the wrap block hands back
  always_ff @(posedge aclk) begin
    if (!aresetn) ptr_r <= 16'h0000;
    else if (load) ptr_r <= load_val;
    else if (dir_in != 2'b00) ptr_r <= addr_back;
  end
endmodule // mwr_core_model

//--- verification/test_mwr_top.sv
// self-checking bench for the modulo address wrap block
`timescale 1ns/1ps
`include "mwr_params.svh"
module test_mwr_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, x_wrap_hit, y_wrap_hit, ld;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, x_rd_ptr_sel, x_wr_ptr_sel, y_ptr_sel;
  logic [1:0]  s_axi_bresp, s_axi_rresp, x_rd_dir, x_wr_dir, y_dir, r;
  logic [15:0] x_rd_addr, x_rd_addr_out, x_wr_addr, x_wr_addr_out, y_addr, y_addr_out, xlv, ylv;
  logic [31:0] v;
  int bad_count, cmp_count;
  mwr_top mwr_top_inst (.*);
  mwr_core_model mwr_core_model_inst (.aclk(aclk), .aresetn(aresetn), .load(ld), .load_val(xlv),
    .addr_back(x_rd_addr_out), .dir_in(x_rd_dir), .cand(x_rd_addr));
  mwr_core_model mwr_core_model_y_inst (.aclk(aclk), .aresetn(aresetn), .load(ld), .load_val(ylv),
    .addr_back(y_addr_out), .dir_in(y_dir), .cand(y_addr));
  task automatic chk(input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // write: address and data offered together; each is released at the rising edge that takes it,
  // and the response is taken at the rising edge where bvalid is seen with bready high
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rs);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 40);
    rs = s_axi_bresp;
    chk(32'(s_axi_bvalid), 32'h1);
    s_axi_bready <= 1'b0;
    @(posedge aclk); // one edge gap so the next request never collides
  endtask
  // read: address held until taken, data taken at the edge where rvalid is seen
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
    int n;
    n = 0;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 40);
    {d, rs} = {s_axi_rdata, s_axi_rresp};
    chk(32'(s_axi_rvalid), 32'h1);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic load(input logic [15:0] a, b);
    {ld, xlv, ylv} <= {1'b1, a, b};
    @(posedge aclk);
    ld <= 1'b0;
  endtask
  // one core access in x (s=0) or y (s=1): result same cycle, wrap flag next cycle
  task automatic step(input logic s, input logic [1:0] d, input logic [15:0] e, input logic w);
    if (s) y_dir <= d;
    else x_rd_dir <= d;
    @(negedge aclk);
    chk(32'(s ? y_addr_out : x_rd_addr_out), 32'(e));
    @(posedge aclk);
    {x_rd_dir, y_dir} <= 4'h0;
    @(negedge aclk);
    chk(32'(s ? y_wrap_hit : x_wrap_hit), 32'(w));
    @(posedge aclk);
  endtask
  task automatic t_regs();
    rd(`MWR_OFF_CONTROL, v, r);
    chk(v, 32'h0000_00ff);
    for (int i = 1; i < 5; i++) begin
      rd(12'(i * 4), v, r);
      chk(v, 32'h0);
    end
    wr(`MWR_OFF_XSTART, 32'habcd_1234, r);
    rd(`MWR_OFF_XSTART, v, r);
    chk(v, 32'h1234);
    wr(12'h018, 32'h1, r);
    chk(32'(r), 32'(`MWR_RESP_SLVERR));
    rd(12'h018, v, r);
    chk({v[29:0], r}, 32'(`MWR_RESP_SLVERR));
    wr(`MWR_OFF_STATUS, 32'h0, r);
    chk(32'(r), 32'(`MWR_RESP_SLVERR));
  endtask
  task automatic t_x();
    wr(`MWR_OFF_XSTART, 32'h1000, r);
    wr(`MWR_OFF_XEND, 32'h101f, r);
    wr(`MWR_OFF_CONTROL, 32'h80f3, r);
    load(16'h101e, 16'h0);
    step(0, 2'b01, 16'h1000, 1);
    step(0, 2'b10, 16'h101f, 1);
    step(0, 2'b10, 16'h101d, 0);
    {x_wr_ptr_sel, x_wr_addr, x_wr_dir} <= {4'h3, 16'h0ffe, 2'b10};
    @(negedge aclk);
    chk(32'(x_wr_addr_out), 32'h101f);
    @(posedge aclk);
    x_wr_dir <= 2'b00;
    wr(`MWR_OFF_CONTROL, 32'h00f3, r);
    load(16'h101e, 16'h0);
    step(0, 2'b01, 16'h1020, 0);
    wr(`MWR_OFF_CONTROL, 32'h800f, r);
    x_rd_ptr_sel <= 4'hf;
    step(0, 2'b01, 16'h1022, 0);
  endtask
  task automatic t_y();
    wr(`MWR_OFF_YSTART, 32'h2001, r);
    rd(`MWR_OFF_YSTART, v, r);
    chk(v, 32'h2000);
    wr(`MWR_OFF_YEND, 32'h203e, r);
    rd(`MWR_OFF_YEND, v, r);
    chk(v, 32'h203f);
    wr(`MWR_OFF_CONTROL, 32'h402f, r);
    y_ptr_sel <= 4'h2;
    load(16'h0, 16'h203e);
    step(1, 2'b01, 16'h2000, 1);
    step(1, 2'b10, 16'h203e, 1);
    rd(`MWR_OFF_STATUS, v, r);
    chk(v & 32'hffff_cfff, 32'h001f_803f);
  endtask
  // reset in mid-run: registers written earlier must come back to their reset values
  task automatic t_rst();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`MWR_OFF_CONTROL, v, r);
    chk(v, 32'(`MWR_CTRL_INIT));
    rd(`MWR_OFF_YEND, v, r);
    chk(v, 32'(`MWR_ADDR_RST));
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    #2_000_000;
    bad_count++;
    print_verdict();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, ld} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, x_wr_addr, xlv, ylv} = '0;
    {x_rd_dir, x_wr_dir, y_dir, x_wr_ptr_sel, s_axi_wstrb} = {10'h0, 4'hf};
    {x_rd_ptr_sel, y_ptr_sel} = {4'h3, 4'hf};
    {bad_count, cmp_count} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_x();
    t_y();
    t_rst();
    print_verdict();
  end
endmodule // test_mwr_top
